// *** rtl/ref_ctl_pkg.sv ***
// constants, register layouts and types of the reference select, lock and holdover block
// Notes on behaviour
// [RULE1] manual mode: choice 0..2 picks active input
// [RULE2] manual/pin mode keeps selected buffer running
// [RULE3] manual choice 3 enters holdover, relock after
// [RULE4] pin mode: select pins pick the input
// [RULE5] software sets select pin types to input
// [RULE6] polarity bit inverts the select pins
// [RULE7] automatic mode: priority input 0, 1, 2
// [RULE8] automatic mode: only enabled buffers are eligible
// [RULE9] in-window comparison increments lock count
// [RULE10] lock asserts when count reaches programmed value; code sets it one in-window comparison later
// [RULE11] one out-of-window comparison drops lock
// [RULE12] out-of-window comparison restarts count at zero
// [RULE13] status pins show loop1, loop2 or both
// [RULE14] holdover only when holdover_enable set
// [RULE15] holdover: pump off, lock1 low, status high
// [RULE16] holdover keeps relocking loop1 to active input
// [RULE17] fixed dac enable selects fixed value
// [RULE18] otherwise tracking uses last tracked value
// [RULE19] dac_acquired after capture, routable to pins
// [RULE20] tracking update every multiplier times counter ticks
// [RULE21] software keeps update rate at most 100 kHz
// [RULE22] tracked dac value readable by software
// [RULE23] holdover status routable to either pin
// [RULE24] holdover ends on reprogram or loss cleared
package ref_ctl_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] addr_ctrl   = 8'h00; // mode and holdover control
  localparam logic [7:0] addr_lock   = 8'h04; // lock count targets
  localparam logic [7:0] addr_dac    = 8'h08; // fixed value and rate counter
  localparam logic [7:0] addr_route  = 8'h0c; // multiplier, pin routing, timeout
  localparam logic [7:0] addr_status = 8'h10; // read-only state
  localparam logic [31:0] reset_word = 32'h0000_0000; // all fields reset low

  // status pin source codes
  localparam logic [2:0] pin_lock1    = 3'h0; // first loop lock
  localparam logic [2:0] pin_lock2    = 3'h1; // second loop lock
  localparam logic [2:0] pin_both     = 3'h2; // both loops locked
  localparam logic [2:0] pin_holdover = 3'h3; // holdover status
  localparam logic [2:0] pin_dac      = 3'h4; // dac acquired
  localparam logic [1:0] choice_hold  = 2'h3; // select value meaning holdover

  // ---------------------------------------------------------------
  // register layouts
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [16:0] unused;               // reads zero
    logic        tracking_enable;      // track tuning node
    logic        fixed_dac_enable;     // fixed holdover value
    logic        holdover_enable;      // allow holdover
    logic        holdover_exit_choice; // 0: leave on loss cleared
    logic        loss_of_signal_enable;// loss detection used
    logic        select_pin_polarity;  // invert select pins
    logic        select1_pin_type;     // 1: second pin is input
    logic        select0_pin_type;     // 1: first pin is input
    logic [2:0]  input_buffer_enable;  // per reference
    logic [1:0]  manual_input_choice;  // 0..2 input, 3 holdover
    logic        pin_select_enable;    // pin select mode
    logic        auto_select_enable;   // priority mode
  } ctrl_t;

  typedef struct packed {
    logic [1:0]  unused_hi;            // reads zero
    logic [13:0] loop2_lock_count;     // second loop target
    logic [1:0]  unused_lo;            // reads zero
    logic [13:0] loop1_lock_count;     // first loop target
  } lock_t;

  typedef struct packed {
    logic [7:0]  unused_hi;            // reads zero
    logic [7:0]  dac_rate_counter;     // outer divider
    logic [5:0]  unused_lo;            // reads zero
    logic [9:0]  fixed_dac_value;      // fixed holdover code
  } dac_t;

  typedef struct packed {
    logic [4:0]  unused_hi;            // reads zero
    logic [2:0]  loss_timeout;         // to loss detectors
    logic        unused_b;             // reads zero
    logic [2:0]  status_pin2_select;   // source of pin 2
    logic        unused_a;             // reads zero
    logic [2:0]  status_pin1_select;   // source of pin 1
    logic [1:0]  unused_lo;            // reads zero
    logic [13:0] dac_rate_multiplier;  // inner divider
  } route_t;

  // loop lock detector state
  typedef struct packed {
    logic [13:0] count;                // in-window run length
    logic        locked;               // lock indicator
  } lock_det_t;

  typedef enum logic [1:0] {
    st_closed = 2'b01,                 // loop1 closed
    st_hold   = 2'b10                  // loop1 open, dac drives
  } hold_st_t;
endpackage

// *** rtl/ref_select_lock_holdover.sv ***
// reference selection, digital lock detect and holdover control
`timescale 1ns/1ps
`default_nettype none
module ref_select_lock_holdover #(
  parameter int dac_width = 10           // tuning dac width
) (
  input  wire logic                 clk_sys,        // 10 MHz system clock
  input  wire logic                 rst,            // synchronous, active high
  input  wire logic [7:0]           addr,           // register byte address
  input  wire logic [31:0]          wdata,          // write data
  input  wire logic                 wr,             // write strobe
  input  wire logic                 rd,             // read strobe
  output logic [31:0]               rdata,          // read data, cycle after rd
  input  wire logic [2:0]           los,            // loss of signal per input
  input  wire logic                 sel0_in,        // first select pin
  input  wire logic                 status_out1_in, // pin 1 level, second select
  output logic                      status_out1,    // pin 1 drive value
  output logic                      status_out1_oe, // pin 1 driven
  output logic                      status_out2,    // pin 2
  input  wire logic [1:0]           cmp_valid,      // phase comparison done, per loop
  input  wire logic [1:0]           cmp_in_window,  // comparison inside window
  input  wire logic                 pd1_tick,       // first loop detector clock enable
  input  wire logic [dac_width-1:0] tune_value,     // present tuning code
  output logic [1:0]                active_input,   // selected reference
  output logic [2:0]                buffer_run,     // input buffers powered
  output logic                      pump_hiz,       // loop1 pump released
  output logic [dac_width-1:0]      dac_value,      // holdover dac code
  output logic [2:0]                loss_timeout,   // to loss detectors
  output logic [1:0]                lock_out,       // lock indicators
  output logic                      holdover        // holdover status
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    ref_ctl_pkg::ctrl_t       ctrl;      // mode register
    ref_ctl_pkg::lock_t       lock;      // lock targets
    ref_ctl_pkg::dac_t        dac;       // dac settings
    ref_ctl_pkg::route_t      route;     // routing
    ref_ctl_pkg::lock_det_t [1:0] det;   // per loop detector
    ref_ctl_pkg::hold_st_t    st;        // holdover machine
    logic [1:0]               active;    // active reference
    logic [13:0]              mult_cnt;  // inner rate count
    logic [7:0]               rate_cnt;  // outer rate count
    logic [dac_width-1:0]     track;     // tracked code
    logic                     acquired;  // tracked code valid
    logic [dac_width-1:0]     hold_code; // applied code
    logic                     pin1;      // pin 1 value
    logic                     pin2;      // pin 2 value
    logic [31:0]              rdata;     // read data
  } state_t;

  state_t s;       // registered state
  state_t next_s;  // next state

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // status pin multiplexer, used for both pins
  function automatic logic pin_src(input logic [2:0] code, input logic [1:0] lk,
                                   input logic ho, input logic acq);
    if (code == ref_ctl_pkg::pin_lock1) begin
      pin_src = lk[0];                   // first loop lock
    end else if (code == ref_ctl_pkg::pin_lock2) begin
      pin_src = lk[1];                   // second loop lock
    end else if (code == ref_ctl_pkg::pin_both) begin
      pin_src = &lk;                     // both loops
    end else if (code == ref_ctl_pkg::pin_holdover) begin
      pin_src = ho;                      // holdover
    end else if (code == ref_ctl_pkg::pin_dac) begin
      pin_src = acq;                     // dac acquired
    end else begin
      pin_src = 1'b0;                    // unused codes
    end
  endfunction

  logic [1:0] pin_choice;   // decoded select pin value
  logic [2:0] eligible;     // usable in automatic mode
  logic       any_good;     // some eligible input has signal
  logic [1:0] auto_pick;    // highest priority usable input
  logic       want_hold;    // entry condition
  logic       ctrl_write;   // software reprograms mode
  logic       pin_mode;     // pin select mode active
  logic       manual_mode;  // manual mode active
  logic       rate_hit;     // tracking update moment

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    manual_mode = !s.ctrl.auto_select_enable && !s.ctrl.pin_select_enable;
    pin_mode    = !s.ctrl.auto_select_enable && s.ctrl.pin_select_enable;
    ctrl_write  = wr && (addr == ref_ctl_pkg::addr_ctrl);
    // select pins, gated by pin type, optionally inverted
    pin_choice = {s.ctrl.select1_pin_type & status_out1_in,
                  s.ctrl.select0_pin_type & sel0_in};                      // RULE4
    if (s.ctrl.select_pin_polarity) begin
      pin_choice = ~pin_choice;                                           // RULE6
    end
    // automatic priority pick
    eligible = s.ctrl.input_buffer_enable & ~(los & {3{s.ctrl.loss_of_signal_enable}}); // RULE8
    any_good = |eligible;
    if (eligible[0]) begin
      auto_pick = 2'h0;                                                   // RULE7
    end else if (eligible[1]) begin
      auto_pick = 2'h1;                                                   // RULE7
    end else begin
      auto_pick = 2'h2;                                                   // RULE7
    end
    // active reference
    if (manual_mode) begin
      if (s.ctrl.manual_input_choice != ref_ctl_pkg::choice_hold) begin
        next_s.active = s.ctrl.manual_input_choice;                       // RULE1
      end
    end else if (pin_mode) begin
      if (pin_choice != ref_ctl_pkg::choice_hold) begin
        next_s.active = pin_choice;                                       // RULE4
      end
    end else if (any_good) begin
      next_s.active = auto_pick;                                          // RULE7
    end
    // holdover machine
    want_hold = (manual_mode && s.ctrl.manual_input_choice == ref_ctl_pkg::choice_hold) // RULE3
             || (pin_mode && pin_choice == ref_ctl_pkg::choice_hold)
             || (!manual_mode && !pin_mode && s.ctrl.loss_of_signal_enable && !any_good);
    case (s.st)
      ref_ctl_pkg::st_closed: begin
        if (s.ctrl.holdover_enable && want_hold) begin
          next_s.st = ref_ctl_pkg::st_hold;                               // RULE14
        end
      end
      ref_ctl_pkg::st_hold: begin
        if (ctrl_write || !s.ctrl.holdover_enable) begin
          next_s.st = ref_ctl_pkg::st_closed;                             // RULE24
        end else if (!manual_mode && !pin_mode && !s.ctrl.holdover_exit_choice && any_good) begin
          next_s.st = ref_ctl_pkg::st_closed;                             // RULE24
        end
      end
      default: begin
        next_s.st = ref_ctl_pkg::st_closed;  // illegal code recovery
      end
    endcase
    // lock detectors, loop1 keeps counting in holdover to relock
    for (int i = 0; i < 2; i++) begin
      if (cmp_valid[i]) begin
        if (cmp_in_window[i]) begin
          if (s.det[i].count != 14'h3fff) begin
            next_s.det[i].count = s.det[i].count + 14'h0001;              // RULE9
          end
        end else begin
          next_s.det[i].count  = 14'h0000;                                // RULE12
          next_s.det[i].locked = 1'b0;                                    // RULE11
        end
      end
    end
    if (cmp_valid[0] && cmp_in_window[0] && s.det[0].count >= s.lock.loop1_lock_count) begin
      next_s.det[0].locked = 1'b1;                                        // RULE10 RULE16
    end
    if (cmp_valid[1] && cmp_in_window[1] && s.det[1].count >= s.lock.loop2_lock_count) begin
      next_s.det[1].locked = 1'b1;                                        // RULE10
    end
    if (next_s.st == ref_ctl_pkg::st_hold) begin
      next_s.det[0].locked = 1'b0;                                        // RULE15
    end
    // tracking dac rate divider on loop1 detector ticks
    rate_hit = 1'b0;
    if (!s.ctrl.tracking_enable || s.st == ref_ctl_pkg::st_hold) begin
      next_s.mult_cnt = 14'h0000;
      next_s.rate_cnt = 8'h00;
      if (!s.ctrl.tracking_enable) begin
        next_s.acquired = 1'b0;
      end
    end else if (pd1_tick) begin
      if (s.mult_cnt + 14'h0001 >= s.route.dac_rate_multiplier) begin
        next_s.mult_cnt = 14'h0000;
        if (s.rate_cnt + 8'h01 >= s.dac.dac_rate_counter) begin
          next_s.rate_cnt = 8'h00;
          rate_hit = 1'b1;                                                // RULE20
        end else begin
          next_s.rate_cnt = s.rate_cnt + 8'h01;
        end
      end else begin
        next_s.mult_cnt = s.mult_cnt + 14'h0001;
      end
    end
    if (rate_hit) begin
      next_s.track    = tune_value;                                       // RULE20
      next_s.acquired = 1'b1;                                             // RULE19
    end
    // applied dac code during holdover
    if (s.ctrl.fixed_dac_enable) begin
      next_s.hold_code = s.dac.fixed_dac_value[dac_width-1:0];            // RULE17
    end else begin
      next_s.hold_code = s.track;                                         // RULE18
    end
    // status pins
    next_s.pin1 = pin_src(s.route.status_pin1_select, {s.det[1].locked, s.det[0].locked},
                          s.st == ref_ctl_pkg::st_hold, s.acquired);      // RULE13 RULE19 RULE23
    next_s.pin2 = pin_src(s.route.status_pin2_select, {s.det[1].locked, s.det[0].locked},
                          s.st == ref_ctl_pkg::st_hold, s.acquired);      // RULE13 RULE19 RULE23
    // register writes
    if (wr) begin
      if (addr == ref_ctl_pkg::addr_ctrl) begin
        next_s.ctrl = wdata;
        next_s.ctrl.unused = '0;
      end else if (addr == ref_ctl_pkg::addr_lock) begin
        next_s.lock = wdata;
        next_s.lock.unused_hi = '0;
        next_s.lock.unused_lo = '0;
      end else if (addr == ref_ctl_pkg::addr_dac) begin
        next_s.dac = wdata;
        next_s.dac.unused_hi = '0;
        next_s.dac.unused_lo = '0;
      end else if (addr == ref_ctl_pkg::addr_route) begin
        next_s.route = wdata;
        next_s.route.unused_hi = '0;
        next_s.route.unused_lo = '0;
        next_s.route.unused_a  = 1'b0;
        next_s.route.unused_b  = 1'b0;
      end
    end
    // register reads, unmapped reads zero
    next_s.rdata = 32'h0000_0000;
    if (rd) begin
      if (addr == ref_ctl_pkg::addr_ctrl) begin
        next_s.rdata = s.ctrl;
      end else if (addr == ref_ctl_pkg::addr_lock) begin
        next_s.rdata = s.lock;
      end else if (addr == ref_ctl_pkg::addr_dac) begin
        next_s.rdata = s.dac;
      end else if (addr == ref_ctl_pkg::addr_route) begin
        next_s.rdata = s.route;
      end else if (addr == ref_ctl_pkg::addr_status) begin
        next_s.rdata = {10'h000, s.active, s.acquired, s.st == ref_ctl_pkg::st_hold,
                        s.det[1].locked, s.det[0].locked,
                        6'h00, 10'(s.track)};                             // RULE22
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s        <= '0;
      s.st     <= ref_ctl_pkg::st_closed;
      s.ctrl   <= ref_ctl_pkg::reset_word;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign rdata          = s.rdata;
  assign active_input   = s.active;
  assign holdover       = (s.st == ref_ctl_pkg::st_hold);                 // RULE15
  assign pump_hiz       = (s.st == ref_ctl_pkg::st_hold);                 // RULE15
  assign dac_value      = s.hold_code;
  assign lock_out       = {s.det[1].locked, s.det[0].locked};
  assign loss_timeout   = s.route.loss_timeout;
  assign status_out1    = s.pin1;
  assign status_out1_oe = !(s.ctrl.pin_select_enable && s.ctrl.select1_pin_type); // RULE4
  assign status_out2    = s.pin2;
  // selected buffer stays powered outside automatic mode
  generate
    for (genvar g = 0; g < 3; g++) begin : g_buf
      assign buffer_run[g] = s.ctrl.input_buffer_enable[g]
                           | (!s.ctrl.auto_select_enable && s.active == 2'(g)); // RULE2
    end
  endgenerate

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_manual_choice: assert property ((manual_mode && s.ctrl.manual_input_choice != ref_ctl_pkg::choice_hold) |=> // RULE1
    (active_input == $past(s.ctrl.manual_input_choice))) else $error("manual choice not applied");
  a_buffer_kept: assert property (!s.ctrl.auto_select_enable |-> buffer_run[s.active]) // RULE2
    else $error("selected buffer off");
  a_manual_hold: assert property ((manual_mode && s.ctrl.holdover_enable // RULE3
    && s.ctrl.manual_input_choice == ref_ctl_pkg::choice_hold && !wr) |=> holdover)
    else $error("manual holdover not entered");
  a_hold_gated: assert property (!s.ctrl.holdover_enable && !holdover |=> !holdover) // RULE14
    else $error("holdover without enable");
  a_hold_open: assert property (holdover |-> pump_hiz && !lock_out[0]) // RULE15
    else $error("loop1 not open in holdover");
  a_lock_drop: assert property ((cmp_valid[0] && !cmp_in_window[0]) |=> // RULE11
    (!lock_out[0] && s.det[0].count == 14'h0000)) else $error("lock not dropped");
  a_lock_rise: assert property ($rose(lock_out[1]) |-> // RULE10
    $past(s.det[1].count) >= $past(s.lock.loop2_lock_count)) else $error("lock too early");
  a_fixed_dac: assert property ((s.ctrl.fixed_dac_enable && !wr) ##1 s.ctrl.fixed_dac_enable |-> // RULE17
    dac_value == $past(s.dac.fixed_dac_value[dac_width-1:0])) else $error("fixed dac not used");
  a_reprog_exit: assert property ((holdover && ctrl_write) |=> !holdover) // RULE24
    else $error("holdover kept after reprogram");

  c_hold_enter: cover property (!holdover ##1 holdover);
  c_lock_both: cover property (lock_out == 2'b11);
  c_track: cover property ($rose(s.acquired));
  c_auto_switch: cover property (s.ctrl.auto_select_enable && $changed(active_input));
endmodule
`default_nettype wire

// *** testbench/ref_sources_model.sv ***
// behavioural model of the reference sources and loop phase detectors
`timescale 1ns/1ps
`default_nettype none
module ref_sources_model (
  input  wire logic       clk_sys,       // system clock
  output logic [2:0]      los,           // loss of signal per input
  output logic [1:0]      cmp_valid,     // comparison done per loop
  output logic [1:0]      cmp_in_window, // comparison inside window
  output logic            pd1_tick       // first loop detector tick
);
  // ---------------------------------------------------------------
  // levels and pulses
  // ---------------------------------------------------------------
  initial begin
    los           = 3'h0;
    cmp_valid     = 2'h0;
    cmp_in_window = 2'h0;
    pd1_tick      = 1'b0;
  end
  // detector tick every second cycle, paused by a loop1 compare
  always @(posedge clk_sys) begin
    pd1_tick <= ~pd1_tick & ~cmp_valid[0];
  end
  // loss level, held until changed; any pattern of the three inputs
  task automatic set_los(input logic [2:0] v);
    @(posedge clk_sys);
    los <= v;
  endtask
  // one-cycle comparison pulse; window result only valid with pulse
  task automatic compare(input logic [1:0] mask, input logic [1:0] win);
    @(posedge clk_sys);
    cmp_valid     <= mask;
    cmp_in_window <= win;
    @(posedge clk_sys);
    cmp_valid     <= 2'h0;
    cmp_in_window <= ~win;
  endtask
endmodule
`default_nettype wire

// *** testbench/ref_select_lock_holdover_tb.sv ***
// self-checking testbench of the reference select, lock and holdover block
`timescale 1ns/1ps
`default_nettype none
module ref_select_lock_holdover_tb;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clk_sys, rst, wr, rd, sel0_in, sel1_lvl; // driven by bench
  logic [7:0]  addr;                                   // register address
  logic [31:0] wdata, rdata, word;                     // bus data
  logic        status_out1, status_out1_oe, status_out2, pump_hiz, holdover, pd1_tick;
  logic [1:0]  active_input, lock_out, cmp_valid, cmp_in_window;
  logic [2:0]  buffer_run, loss_timeout, los;
  logic [9:0]  dac_value;
  wire         status_out1_in = status_out1_oe ? status_out1 : sel1_lvl; // shared pin
  int          miscompares, checks_done;
  // ---------------------------------------------------------------
  // instances
  // ---------------------------------------------------------------
  ref_select_lock_holdover u_ref_select_lock_holdover (.clk_sys(clk_sys), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .los(los), .sel0_in(sel0_in),
    .status_out1_in(status_out1_in), .status_out1(status_out1), .status_out1_oe(status_out1_oe),
    .status_out2(status_out2), .cmp_valid(cmp_valid), .cmp_in_window(cmp_in_window),
    .pd1_tick(pd1_tick), .tune_value(10'h0aa), .active_input(active_input), .buffer_run(buffer_run),
    .pump_hiz(pump_hiz), .dac_value(dac_value), .loss_timeout(loss_timeout), .lock_out(lock_out),
    .holdover(holdover));
  ref_sources_model u_ref_sources_model (.clk_sys(clk_sys), .los(los), .cmp_valid(cmp_valid),
    .cmp_in_window(cmp_in_window), .pd1_tick(pd1_tick));
  // ---------------------------------------------------------------
  // bus, wait and compare tasks
  // ---------------------------------------------------------------
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr    <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic settle();
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t word got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t level got %b exp %b", $time, got, exp);
    end
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic manual_select();
    for (int i = 0; i < 3; i++) begin
      reg_write(ref_ctl_pkg::addr_ctrl, 32'(i) << 2); // buffers all disabled
      settle();
      check_word(32'(active_input), 32'(i));
      check_bit(buffer_run[i], 1'b1);
    end
    reg_read(8'h14, word);
    check_word(word, 32'h0); // unmapped place reads zero
  endtask
  task automatic pin_select();
    sel0_in  <= 1'b1;
    sel1_lvl <= 1'b0;
    reg_write(ref_ctl_pkg::addr_ctrl, 32'h0000_0182); // pin types set to input
    settle();
    check_bit(status_out1_oe, 1'b0);
    check_word(32'(active_input), 32'h1);
    reg_write(ref_ctl_pkg::addr_ctrl, 32'h0000_0382);
    settle();
    check_word(32'(active_input), 32'h2);
  endtask
  task automatic lock_detect();
    reg_write(ref_ctl_pkg::addr_lock, 32'h0002_0002); // both targets two
    reg_write(ref_ctl_pkg::addr_route, 32'h0513_000a); // pin1 holdover, pin2 loop2 lock, slow rate
    for (int i = 0; i < 3; i++) u_ref_sources_model.compare(2'b11, 2'b11);
    settle();
    check_word(32'(lock_out), 32'h3);
    check_word(32'(loss_timeout), 32'h5);
    check_bit(status_out2, 1'b1);
    u_ref_sources_model.compare(2'b01, 2'b00);
    settle();
    check_word(32'(lock_out), 32'h2);
    for (int i = 0; i < 2; i++) u_ref_sources_model.compare(2'b01, 2'b01);
    settle();
    check_bit(lock_out[0], 1'b0);
    u_ref_sources_model.compare(2'b01, 2'b01);
    settle();
    check_bit(lock_out[0], 1'b1);
  endtask
  task automatic manual_holdover();
    reg_write(ref_ctl_pkg::addr_dac, 32'h0005_0155); // 10 x 5 ticks per update
    reg_write(ref_ctl_pkg::addr_ctrl, 32'h0000_600c); // choice 3, no holdover enable
    repeat (110) @(posedge clk_sys); // let tracking capture once
    settle();
    check_bit(holdover, 1'b0);
    reg_write(ref_ctl_pkg::addr_ctrl, 32'h0000_700c); // fixed and tracking both on
    settle();
    check_word({holdover, pump_hiz, 18'h0, lock_out, dac_value}, {2'b11, 20'h2, 10'h155});
    check_bit(status_out1, 1'b1);
    reg_read(ref_ctl_pkg::addr_status, word);
    check_bit(word[18], 1'b1);
    check_bit(word[19], 1'b1);
    check_word(32'(word[9:0]), 32'h0aa);
    reg_write(ref_ctl_pkg::addr_ctrl, 32'h0000_0004);
    settle();
    check_word({31'h0, holdover}, 32'h0);
    check_word(32'(active_input), 32'h1);
  endtask
  task automatic auto_select();
    reg_write(ref_ctl_pkg::addr_ctrl, 32'h0000_1471); // auto, loss used, holdover on
    u_ref_sources_model.set_los(3'b001);
    settle();
    check_word(32'(active_input), 32'h1);
    u_ref_sources_model.set_los(3'b111);
    settle();
    check_bit(holdover, 1'b1);
    u_ref_sources_model.set_los(3'b011);
    settle();
    check_word({30'h0, holdover, pump_hiz}, 32'h0);
    check_word(32'(active_input), 32'h2);
    reg_write(ref_ctl_pkg::addr_ctrl, 32'h0000_5431); // input 2 disabled, tracking on
    settle();
    check_bit(holdover, 1'b1);
    check_word(32'(dac_value), 32'h0aa);
  endtask
  // ---------------------------------------------------------------
  // clock, sequence, watchdog and verdict
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    {rst, wr, rd, sel0_in, sel1_lvl, addr, wdata, miscompares, checks_done} = '0;
    rst = 1'b1;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    manual_select();
    pin_select();
    lock_detect();
    manual_holdover();
    auto_select();
    tally_and_finish();
  end
  initial begin
    #2000000;
    miscompares++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
